// >>> dv/tb_voltmeter_gpio_port.sv
// tb_voltmeter_gpio_port: host and device ends joined by the cable
// assumes: software register port on the host, user side of device
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_voltmeter_gpio_port;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        irq;
  logic        rdg_valid = 1'b0;
  logic [15:0] rdg_data = 16'h0000;
  logic        dest_is_port = 1'b1;
  logic [2:0]  src = 3'h0;
  logic [2:0]  slp = 3'h0;
  logic        notify_end_mode = 1'b0;
  logic        notify_dav_mode = 1'b1;
  logic        scan_done = 1'b0;
  logic        intr_enable = 1'b0;
  logic        ibus_busy = 1'b0;
  logic        rdg_ready;
  logic        buf_overflow;
  wire logic [2:0] tp;
  int          errors = 0;
  int          comparisons = 0;
  int          tcnt [3] = '{0, 0, 0};
  logic [15:0] v;
  vgp_if vgp_if_i ();
  vgp_dev #(.DEPTH(4), .AW(2)) vgp_dev_i (.clk_sys(clk_sys), .resetn(resetn), .lnk(vgp_if_i),
    .rdg_valid(rdg_valid), .rdg_data(rdg_data), .dest_is_port(dest_is_port),
    .scan_trigger_source(src[0]), .scan_trigger_slope(slp[0]), .meas_trigger_source(src[1]),
    .meas_trigger_slope(slp[1]), .stop_trigger_source(src[2]), .stop_trigger_slope(slp[2]),
    .notify_end_mode(notify_end_mode), .notify_dav_mode(notify_dav_mode), .scan_done(scan_done),
    .intr_enable(intr_enable), .ibus_busy(ibus_busy), .rdg_ready(rdg_ready),
    .scan_trig(tp[0]), .meas_trig(tp[1]), .stop_trig(tp[2]), .buf_overflow(buf_overflow));
  vgp_host vgp_host_i (.clk_sys(clk_sys), .resetn(resetn), .lnk(vgp_if_i), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  vgp_sva vgp_sva_i (.clk_sys(clk_sys), .resetn(resetn), .dout(vgp_if_i.dout), .din(vgp_if_i.din),
    .host_strobe_line_n(vgp_if_i.host_strobe_line_n), .peripheral_ack_line(vgp_if_i.peripheral_ack_line),
    .io_dir_read(vgp_if_i.io_dir_read), .addr_data_select_n(vgp_if_i.addr_data_select_n));
  ////////////////////////////////////////
  // clock and trigger pulse counting
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 3; i++)
      if (tp[i] === 1'b1)
        tcnt[i]++;
  end
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // register port cycles
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // link word transfers, bounded wait on busy
  task automatic xfer(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] s;
    int          n;
    wreg(a, d);
    n = 0;
    do
    begin
      rreg(vgp_pkg::HREG_LINK_STAT, s);
      n++;
    end
    while (s[5] !== 1'b0 && n < 100);
    `CHK(s[5], 1'b0)
  endtask
  task automatic get(output logic [15:0] d);
    xfer(vgp_pkg::HREG_READ_GO, 16'h0000);
    rreg(vgp_pkg::HREG_WORD_IN, d);
  endtask
  task automatic push(input logic [15:0] d);
    @(posedge clk_sys);
    rdg_valid <= 1'b1;
    rdg_data <= d;
    @(posedge clk_sys);
    rdg_valid <= 1'b0;
  endtask
  task automatic tw(input logic [15:0] d);
    wreg(vgp_pkg::HREG_CTRL, d);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irq, e)
  endtask
  initial
  begin
    #1000000;
    errors++;
    stop_test();
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1 `CHK(rdg_ready, 1'b1)
    rreg(vgp_pkg::HREG_LINK_STAT, v);
    `CHK(v, 16'h0018)
    push(16'ha001);
    get(v);
    `CHK(v, 16'h0000)
    wreg(vgp_pkg::HREG_CTRL, 16'h0005);
    get(v);
    `CHK(v, 16'h0000)
    xfer(vgp_pkg::HREG_WORD_OUT, vgp_pkg::ADDR_DATA_BUF);
    wreg(vgp_pkg::HREG_CTRL, 16'h0004);
    get(v);
    `CHK(v, 16'ha001)
    // status error reporting on, device present: only word-done events
    rreg(vgp_pkg::HREG_INT_STAT, v);
    `CHK(v, 16'h0002)
    @(posedge clk_sys) dest_is_port <= 1'b0;
    push(16'hbad0);
    @(posedge clk_sys) dest_is_port <= 1'b1;
    get(v);
    `CHK(v, 16'h0000)
    // back-to-back readings until full
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      rdg_valid <= 1'b1;
      rdg_data <= 16'(16'h5a00 + i);
      @(posedge clk_sys);
    end
    rdg_valid <= 1'b0;
    #1 `CHK(rdg_ready, 1'b0)
    rreg(vgp_pkg::HREG_LINK_STAT, v);
    `CHK(v, 16'h0019)
    push(16'hbeef);
    #1 `CHK(buf_overflow, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      get(v);
      `CHK(v, 16'(16'h5a00 + i))
    end
    get(v);
    `CHK(v, 16'h0000)
    // internal bus stall during a read
    push(16'h7777);
    @(posedge clk_sys) ibus_busy <= 1'b1;
    wreg(vgp_pkg::HREG_READ_GO, 16'h0000);
    repeat (8) @(posedge clk_sys);
    rreg(vgp_pkg::HREG_LINK_STAT, v);
    `CHK(v[5:4], 2'b10)
    @(posedge clk_sys) ibus_busy <= 1'b0;
    xfer(vgp_pkg::HREG_LINK_STAT, 16'h0000);
    rreg(vgp_pkg::HREG_WORD_IN, v);
    `CHK(v, 16'h7777)
    // each trigger source, both slopes
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys);
      src <= 3'(1 << i);
      slp <= 3'h0;
      tw(16'h0002);
      `CHK(tcnt[i], 0)
      tw(16'h0000);
      `CHK(tcnt[i], 1)
      @(posedge clk_sys) slp <= 3'h7;
      tw(16'h0002);
      `CHK(tcnt[i], 2)
      tw(16'h0000);
      `CHK(tcnt[i], 2)
    end
    `CHK(tcnt[0] + tcnt[1] + tcnt[2], 6)
    // end of scan interrupt, mask and clear
    wreg(vgp_pkg::HREG_INT_CLR, 16'h0007);
    wreg(vgp_pkg::HREG_INT_EN, 16'h0001);
    @(posedge clk_sys);
    notify_dav_mode <= 1'b0;
    notify_end_mode <= 1'b1;
    intr_enable <= 1'b1;
    push(16'h1234);
    @(posedge clk_sys) scan_done <= 1'b1;
    @(posedge clk_sys) scan_done <= 1'b0;
    rreg(vgp_pkg::HREG_LINK_STAT, v);
    `CHK(v, 16'h001e)
    // rising interrupt line latched as the only pending event
    rreg(vgp_pkg::HREG_INT_STAT, v);
    `CHK(v, 16'h0001)
    chk_irq(1'b1);
    wreg(vgp_pkg::HREG_INT_EN, 16'h0000);
    chk_irq(1'b0);
    wreg(vgp_pkg::HREG_INT_EN, 16'h0001);
    chk_irq(1'b1);
    wreg(vgp_pkg::HREG_INT_CLR, 16'h0001);
    chk_irq(1'b0);
    get(v);
    `CHK(v, 16'h1234)
    rreg(vgp_pkg::HREG_LINK_STAT, v);
    `CHK(v, 16'h0018)
    stop_test();
  end
endmodule
`default_nettype wire

// >>> dv/vgp_sva.sv
// vgp_sva: handshake checks on the cable between both ends
// assumes: one clk_sys domain, asynchronous active-low resetn
`timescale 1ns/10ps
`default_nettype none
module vgp_sva (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [15:0] dout,
  input wire logic [15:0] din,
  input wire logic        host_strobe_line_n,
  input wire logic        peripheral_ack_line,
  input wire logic        io_dir_read,
  input wire logic        addr_data_select_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic        ack_q;
  logic [15:0] adr_q;
  wire         ack_up = peripheral_ack_line && !ack_q;
  // last address word the device accepted
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_q <= 1'b1;
      adr_q <= vgp_pkg::ADDR_RESET;
    end
    else
    begin
      ack_q <= peripheral_ack_line;
      if (ack_up && !io_dir_read && !addr_data_select_n)
        adr_q <= dout;
    end
  end
  ////////////////////////////////////////
  property p_ack_fall; $fell(host_strobe_line_n) |-> ##[1:3] !peripheral_ack_line; endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("ack late after strobe");
  property p_ack_low; $fell(peripheral_ack_line) |-> ##[1:64] peripheral_ack_line; endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack stuck low");
  property p_sel_read; ack_up && io_dir_read && !addr_data_select_n |-> din == 16'h0000; endproperty
  a_sel_read: assert property (p_sel_read) else $error("read with select low gave data");
  property p_buf_path; ack_up && io_dir_read && adr_q != vgp_pkg::ADDR_DATA_BUF |-> din == 16'h0000; endproperty
  a_buf_path: assert property (p_buf_path) else $error("data without buffer path");
  property p_hold; !host_strobe_line_n && !peripheral_ack_line |=> !host_strobe_line_n; endproperty
  a_hold: assert property (p_hold) else $error("strobe released while ack low");
  property p_rise; $rose(host_strobe_line_n) |-> peripheral_ack_line && $past(peripheral_ack_line); endproperty
  a_rise: assert property (p_rise) else $error("strobe rose without ack");
  property p_din; peripheral_ack_line && host_strobe_line_n |=> $stable(din); endproperty
  a_din: assert property (p_din) else $error("read word changed while idle");
  property p_req;
    (!host_strobe_line_n ##1 !host_strobe_line_n) |->
      $stable(dout) && $stable(io_dir_read) && $stable(addr_data_select_n);
  endproperty
  a_req: assert property (p_req) else $error("request moved mid transfer");
  // main scenarios seen
  c_read: cover property (ack_up && io_dir_read && adr_q == vgp_pkg::ADDR_DATA_BUF);
  c_addr: cover property (ack_up && !io_dir_read && !addr_data_select_n);
  c_stall: cover property ($fell(peripheral_ack_line) ##6 !peripheral_ack_line);
endmodule
`default_nettype wire

// >>> rtl/vgp_dev.sv
// vgp_dev: voltmeter end of the parallel port, reading buffer
// assumes: readings arrive packed, host keeps the full handshake
//
// Contract
// - select low marks written word as address
// - address 4 selects the reading buffer
// - select high again permits buffer reads
// - trigger line edge makes scan/measure/stop trigger
// - scan source port, falling slope starts scan
// - host forwards interrupt only when enabled
// - device raises interrupt line high
// - sustain 100k readings per second
// - every transfer waits for internal bus
// - readings leave in packed raw form
// - readings reach port only when destination
// - host status error bit reports or ignores
// - words move by full-mode handshake
// - strobe falls to start, rises to acknowledge
// - ack line shows data valid or accepted
// - device drives sixteen data lines on reads
// - two status lines always driven
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vgp_dev #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  vgp_if.dev               lnk,
  input  wire logic        rdg_valid,
  input  wire logic [15:0] rdg_data,
  input  wire logic        dest_is_port,
  input  wire logic        scan_trigger_source,
  input  wire logic        scan_trigger_slope,
  input  wire logic        meas_trigger_source,
  input  wire logic        meas_trigger_slope,
  input  wire logic        stop_trigger_source,
  input  wire logic        stop_trigger_slope,
  input  wire logic        notify_end_mode,
  input  wire logic        notify_dav_mode,
  input  wire logic        scan_done,
  input  wire logic        intr_enable,
  input  wire logic        ibus_busy,
  output logic             rdg_ready,
  output logic             scan_trig,
  output logic             meas_trig,
  output logic             stop_trig,
  output logic             buf_overflow
);

  typedef enum logic [1:0] {
    VGP_IDLE = 2'b00,
    VGP_WAIT = 2'b01,
    VGP_HOLD = 2'b10
  } vgp_state_t;

  vgp_state_t          state_reg;
  vgp_state_t          state_next;
  logic [15:0]         mem [DEPTH];
  logic [AW-1:0]       wp_reg;
  logic [AW-1:0]       rp_reg;
  logic [AW:0]         cnt_reg;
  logic [15:0]         addr_reg;
  logic [15:0]         din_reg;
  logic                ack_reg;
  logic                strobe_prev_reg;
  logic                trig_prev_reg;
  logic                eos_reg;
  logic                avail_reg;
  logic                intr_reg;
  logic                present_reg;

  ////////////////////////////////////////////////////////////////////////
  // edge selection by slope: high selects high-to-low
  function automatic logic edge_hit(input logic slope_hl, input logic rise, input logic fall);
    edge_hit = slope_hl ? fall : rise;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of handshake and buffer conditions
  wire         strobe_fall = strobe_prev_reg & ~lnk.host_strobe_line_n;
  wire         buf_empty   = (cnt_reg == '0);
  wire         buf_full    = (cnt_reg == (AW+1)'(DEPTH));
  wire         buf_sel     = (addr_reg == vgp_pkg::ADDR_DATA_BUF);
  wire         bus_go      = (state_reg == VGP_WAIT) & ~ibus_busy;
  wire         is_read     = lnk.io_dir_read;
  wire         addr_wr     = bus_go & ~is_read & ~lnk.addr_data_select_n;
  wire         pop         = bus_go & is_read & lnk.addr_data_select_n & buf_sel & ~buf_empty;
  wire         push        = rdg_valid & dest_is_port & ~buf_full;
  wire         trig_rise   = ~trig_prev_reg & lnk.host_trigger_line;
  wire         trig_fall   = trig_prev_reg & ~lnk.host_trigger_line;
  wire [AW:0]  cnt_after   = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  ////////////////////////////////////////////////////////////////////////
  // handshake state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      VGP_IDLE:
      begin
        if (strobe_fall)
          state_next = VGP_WAIT;
      end
      VGP_WAIT:
      begin
        // hold off until internal bus free
        if (!ibus_busy)
          state_next = VGP_HOLD;
      end
      VGP_HOLD:
      begin
        if (lnk.host_strobe_line_n)
          state_next = VGP_IDLE;
      end
      default:
        state_next = VGP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_reg <= VGP_IDLE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // ack line, address capture and read word
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_reg         <= 1'b1;
      strobe_prev_reg <= 1'b1;
      addr_reg        <= vgp_pkg::ADDR_RESET;
      din_reg         <= 16'h0000;
    end
    else
    begin
      strobe_prev_reg <= lnk.host_strobe_line_n;
      // busy after strobe, ready when done
      // ack high marks valid or accepted
      if (strobe_fall && state_reg == VGP_IDLE)
        ack_reg <= 1'b0;
      else if (bus_go)
        ack_reg <= 1'b1;
      // select low makes word an address
      if (addr_wr)
        addr_reg <= lnk.dout;
      if (bus_go && is_read)
        din_reg <= pop ? mem[rp_reg] : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reading buffer, oldest first
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_reg] <= rdg_data;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wp_reg       <= '0;
      rp_reg       <= '0;
      cnt_reg      <= '0;
      rdg_ready    <= 1'b0;
      buf_overflow <= 1'b0;
    end
    else
    begin
      // one pop per handshake, few cycles each
      if (push)
        wp_reg <= wp_reg + AW'(1);
      if (pop)
        rp_reg <= rp_reg + AW'(1);
      cnt_reg      <= cnt_after;
      rdg_ready    <= (cnt_after != (AW+1)'(DEPTH));
      // lost reading when buffer cannot take it
      if (rdg_valid && dest_is_port && buf_full)
        buf_overflow <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger decode from host trigger line
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      trig_prev_reg <= 1'b1;
      scan_trig     <= 1'b0;
      meas_trig     <= 1'b0;
      stop_trig     <= 1'b0;
    end
    else
    begin
      trig_prev_reg <= lnk.host_trigger_line;
      // falling edge with hl slope starts scan
      scan_trig <= scan_trigger_source & edge_hit(scan_trigger_slope, trig_rise, trig_fall);
      meas_trig <= meas_trigger_source & edge_hit(meas_trigger_slope, trig_rise, trig_fall);
      stop_trig <= stop_trigger_source & edge_hit(stop_trigger_slope, trig_rise, trig_fall);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status lines and interrupt
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      eos_reg     <= 1'b0;
      avail_reg   <= 1'b0;
      intr_reg    <= 1'b0;
      present_reg <= 1'b0;
    end
    else
    begin
      present_reg <= 1'b1;
      // end of scan held until buffer drained
      if (scan_done && notify_end_mode)
        eos_reg <= 1'b1;
      else if (cnt_after == '0)
        eos_reg <= 1'b0;
      avail_reg <= notify_dav_mode & (cnt_after != '0);
      intr_reg <= intr_enable &
                  ((scan_done & notify_end_mode) | eos_reg | (notify_dav_mode & (cnt_after != '0)));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cable outputs, all from flops
  assign lnk.din                      = din_reg;
  assign lnk.peripheral_ack_line      = ack_reg;
  assign lnk.peripheral_present_line  = present_reg;
  assign lnk.ext_intr                 = intr_reg;
  assign lnk.end_of_scan_status       = eos_reg;
  assign lnk.reading_available_status = avail_reg;

endmodule
`default_nettype wire

// >>> rtl/vgp_host.sv
// vgp_host: controller end of the parallel port
// assumes: software on a plain register port, read data next cycle
`timescale 1ns/10ps
`default_nettype none
module vgp_host (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  vgp_if.host              lnk,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             irq
);

  typedef enum logic [1:0] {
    VGP_H_IDLE = 2'b00,
    VGP_H_LOW  = 2'b01,
    VGP_H_HIGH = 2'b10
  } vgp_hstate_t;

  vgp_hstate_t  state_reg;
  logic [2:0]   ctrl_reg;
  logic [15:0]  dout_reg;
  logic [15:0]  word_in_reg;
  logic         strobe_n_reg;
  logic         dir_read_reg;
  logic [2:0]   int_stat_reg;
  logic [2:0]   int_en_reg;
  logic         eir_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // register decode and events
  wire        idle     = (state_reg == VGP_H_IDLE);
  wire        go_write = wr & (addr == vgp_pkg::HREG_WORD_OUT) & idle;
  wire        go_read  = wr & (addr == vgp_pkg::HREG_READ_GO) & idle;
  wire        done     = (state_reg == VGP_H_HIGH) & lnk.peripheral_ack_line;
  wire        clr_wr   = wr & (addr == vgp_pkg::HREG_INT_CLR);
  wire        eir_ev   = lnk.ext_intr & ~eir_prev_reg;
  // status error only when reporting enabled
  wire        peripheral_present_line_ev  = ctrl_reg[vgp_pkg::CTRL_PERIPHERAL_PRESENT_LINE_BIT] & ~lnk.peripheral_present_line;
  wire [2:0]  events   = {peripheral_present_line_ev, done, eir_ev};
  wire [15:0] stat_val = {10'h000, ~idle, lnk.peripheral_ack_line, lnk.peripheral_present_line,
                          lnk.ext_intr, lnk.end_of_scan_status, lnk.reading_available_status};
  wire [15:0] rd_val   = (addr == vgp_pkg::HREG_CTRL)      ? {13'h0000, ctrl_reg} :
                         (addr == vgp_pkg::HREG_WORD_IN)   ? word_in_reg :
                         (addr == vgp_pkg::HREG_LINK_STAT) ? stat_val :
                         (addr == vgp_pkg::HREG_INT_STAT)  ? {13'h0000, int_stat_reg} :
                         (addr == vgp_pkg::HREG_INT_EN)    ? {13'h0000, int_en_reg} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // handshake master
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg    <= VGP_H_IDLE;
      strobe_n_reg <= 1'b1;
      dir_read_reg <= 1'b0;
      dout_reg     <= 16'h0000;
      word_in_reg  <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        VGP_H_IDLE:
        begin
          // strobe falls to open a word
          if (go_write || go_read)
          begin
            strobe_n_reg <= 1'b0;
            dir_read_reg <= go_read;
            state_reg    <= VGP_H_LOW;
            if (go_write)
              dout_reg <= wdata;
          end
        end
        VGP_H_LOW:
        begin
          // wait for device to go busy
          if (!lnk.peripheral_ack_line)
            state_reg <= VGP_H_HIGH;
        end
        VGP_H_HIGH:
        begin
          // take word, raise strobe to acknowledge
          if (lnk.peripheral_ack_line)
          begin
            if (dir_read_reg)
              word_in_reg <= lnk.din;
            strobe_n_reg <= 1'b1;
            state_reg    <= VGP_H_IDLE;
          end
        end
        default:
          state_reg <= VGP_H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control, interrupt registers and read port
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg     <= vgp_pkg::CTRL_RESET;
      int_stat_reg <= vgp_pkg::INT_RESET;
      int_en_reg   <= vgp_pkg::INT_RESET;
      eir_prev_reg <= 1'b0;
      rdata        <= 16'h0000;
      irq          <= 1'b0;
    end
    else
    begin
      eir_prev_reg <= lnk.ext_intr;
      if (wr && addr == vgp_pkg::HREG_CTRL)
        ctrl_reg <= wdata[2:0];
      if (wr && addr == vgp_pkg::HREG_INT_EN)
        int_en_reg <= wdata[2:0];
      // set wins over clear
      int_stat_reg <= (int_stat_reg & ~(clr_wr ? wdata[2:0] : 3'h0)) | events;
      rdata        <= rd ? rd_val : 16'h0000;
      // device interrupt forwarded only if enabled
      irq          <= |(int_stat_reg & int_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cable outputs, all from flops
  // control bit set drives select low
  assign lnk.addr_data_select_n = ~ctrl_reg[vgp_pkg::CTRL_ADSEL_BIT];
  assign lnk.host_trigger_line  = ~ctrl_reg[vgp_pkg::CTRL_TRIG_BIT];
  assign lnk.host_strobe_line_n = strobe_n_reg;
  assign lnk.io_dir_read        = dir_read_reg;
  assign lnk.dout               = dout_reg;

endmodule
`default_nettype wire

// >>> rtl/vgp_if.sv
// vgp_if: the parallel cable between host card and voltmeter
// assumes: plain logic levels, no tristate, shared clk_sys
`timescale 1ns/10ps
`default_nettype none
interface vgp_if;
  logic [15:0] dout;                     // host to device word
  logic [15:0] din;                      // device to host word
  logic        host_strobe_line_n;       // low starts a transfer
  logic        peripheral_ack_line;      // high: ready or data valid
  logic        io_dir_read;              // high: host receives
  logic        addr_data_select_n;       // low: word is an address
  logic        host_trigger_line;        // trigger level from host
  logic        peripheral_present_line;  // device powered and cabled
  logic        ext_intr;                 // device interrupt, high
  logic        end_of_scan_status;
  logic        reading_available_status;
  modport dev (
    input  dout, host_strobe_line_n, io_dir_read, addr_data_select_n, host_trigger_line,
    output din, peripheral_ack_line, peripheral_present_line, ext_intr,
    output end_of_scan_status, reading_available_status
  );
  modport host (
    output dout, host_strobe_line_n, io_dir_read, addr_data_select_n, host_trigger_line,
    input  din, peripheral_ack_line, peripheral_present_line, ext_intr,
    input  end_of_scan_status, reading_available_status
  );
endinterface
`default_nettype wire

// >>> rtl/vgp_pkg.sv
// vgp_pkg: shared constants of the voltmeter parallel port
// assumes: one 20 MHz clock, both ends in one clock domain
package vgp_pkg;
  localparam int          CLK_PERIOD_NS   = 50;
  // fastest sustained reading rate, one word every 10 us
  localparam int          RDG_PERIOD_NS   = 10000;
  localparam int          RDG_PERIOD_CYC  = RDG_PERIOD_NS / CLK_PERIOD_NS;
  // device register address of the data-buffer access path
  localparam logic [15:0] ADDR_DATA_BUF   = 16'h0004;
  localparam logic [15:0] ADDR_RESET      = 16'h0000;
  // host register indices on the plain port
  localparam logic [3:0]  HREG_CTRL       = 4'h0;
  localparam logic [3:0]  HREG_WORD_OUT   = 4'h1;
  localparam logic [3:0]  HREG_READ_GO    = 4'h2;
  localparam logic [3:0]  HREG_WORD_IN    = 4'h3;
  localparam logic [3:0]  HREG_LINK_STAT  = 4'h4;
  localparam logic [3:0]  HREG_INT_STAT   = 4'h5;
  localparam logic [3:0]  HREG_INT_CLR    = 4'h6;
  localparam logic [3:0]  HREG_INT_EN     = 4'h7;
  // control register fields
  localparam int          CTRL_ADSEL_BIT  = 0;
  localparam int          CTRL_TRIG_BIT   = 1;
  localparam int          CTRL_PERIPHERAL_PRESENT_LINE_BIT   = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;
  // interrupt status, clear and enable fields
  localparam int          INT_EIR_BIT     = 0;
  localparam int          INT_DONE_BIT    = 1;
  localparam int          INT_PERIPHERAL_PRESENT_LINE_BIT    = 2;
  localparam logic [2:0]  INT_RESET       = 3'h0;
endpackage
